// >>> lssw_consts.vh
// constants and register map for the low-side switch protection and diagnosis block
// Summary of operation
// - channels one to four need injector enable high
// - link timeout switches every stage off
// - per-channel bit: limit only or switch off
// - overcurrent counts after 40 to 70 us filter
// - overcurrent sets fault code, off if configured
// - overtemperature holds outputs off through hysteresis
// - off-state detector latched after diagnosis filter time
// - reading fault register refreshes to present state
// - pull-down disabled: no open load, short kept
// - pull currents disabled on 18-20: no off diagnosis
// - codes 00 none 01 batt/temp 10 open 11 short
// - priority: battery/temp, open load, short, none
`ifndef LSSW_CONSTS_VH
`define LSSW_CONSTS_VH
`define LSSW_NCH          14
`define LSSW_CLK_MHZ      200
`define LSSW_TOC_MIN_US   40
`define LSSW_TOC_MAX_US   70
`define LSSW_TOC_CYC      ((`LSSW_TOC_MIN_US + `LSSW_TOC_MAX_US) / 2 * `LSSW_CLK_MHZ)
`define LSSW_TDIAG_US     100
`define LSSW_TDIAG_CYC    (`LSSW_TDIAG_US * `LSSW_CLK_MHZ)
`define LSSW_CNT_W        16
`define LSSW_ADDR_ON      12'h000
`define LSSW_ADDR_OCMODE  12'h004
`define LSSW_ADDR_PDDIS   12'h008
`define LSSW_ADDR_FAULT   12'h00c
`define LSSW_ADDR_STATUS  12'h010
`define LSSW_ADDR_IRQEN   12'h014
`define LSSW_ADDR_IRQCLR  12'h018
`define LSSW_ADDR_OUTSTAT 12'h01c
`define LSSW_CODE_NONE    2'b00
`define LSSW_CODE_BATT    2'b01
`define LSSW_CODE_OPEN    2'b10
`define LSSW_CODE_SCG     2'b11
`define LSSW_FIRST_UPPER  11
`endif

// >>> lssw_top.v
// low-side switch control, protection and off-state diagnosis with apb registers
//
// The register offsets and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
`include "lssw_consts.vh"
module lssw_top #(
	parameter NCH       = `LSSW_NCH,
	parameter TOC_CYC   = `LSSW_TOC_CYC,
	parameter TDIAG_CYC = `LSSW_TDIAG_CYC
) (
	input  wire             pclk,
	input  wire             presetn,
	input  wire             psel,
	input  wire             penable,
	input  wire             pwrite,
	input  wire [11:0]      paddr,
	input  wire [31:0]      pwdata,
	output reg  [31:0]      prdata,
	output reg              pready,
	output reg              pslverr,
	input  wire             injector_stage_enable,
	input  wire             link_timeout,
	input  wire [NCH-1:0]   oc_raw,
	input  wire [NCH-1:0]   ot_raw,
	input  wire [NCH-1:0]   ol_raw,
	input  wire [NCH-1:0]   scg_raw,
	output reg  [NCH-1:0]   gate_on,
	output reg  [NCH-1:0]   diag_enable,
	output reg  [NCH-1:0]   pull_current_on,
	output reg              irq
);
	localparam CW = `LSSW_CNT_W;
	localparam [CW-1:0] TOC_C = TOC_CYC;
	localparam [CW-1:0] TDG_C = TDIAG_CYC;

	reg  [NCH-1:0]   on_q, ocmode_q, pddis_q, en_q, sts_q;
	reg  [2*NCH-1:0] fault_q;
	reg  [2*NCH-1:0] cur_code;
	reg  [NCH-1:0]   ocdet_q, octrip_q, otl_q, offdiag_q;
	reg  [NCH-1:0]   ol_lat_q, scg_lat_q;
	// three-stage synchronisers for pin and analog inputs
	reg  [1:0]       inj_s, tmo_s;
	reg              inj_q, tmo_q, inj_s3, tmo_s3;
	reg  [NCH-1:0]   oc1, oc2, oc3, ot1, ot2, ot3, ol1, ol2, ol3, sg1, sg2, sg3;
	reg  [NCH-1:0]   oc_f, ot_f, ol_f, sg_f;
	reg  [NCH-1:0]   ev_oc;
	wire             wr = psel & penable & pwrite;
	wire             rd = psel & penable & ~pwrite;
	wire [NCH-1:0]   allow;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			inj_s <= 2'b00; tmo_s <= 2'b00; inj_s3 <= 1'b0; tmo_s3 <= 1'b0;
			inj_q <= 1'b0; tmo_q <= 1'b0;
			oc1 <= {NCH{1'b0}}; oc2 <= {NCH{1'b0}}; oc3 <= {NCH{1'b0}};
			ot1 <= {NCH{1'b0}}; ot2 <= {NCH{1'b0}}; ot3 <= {NCH{1'b0}};
			ol1 <= {NCH{1'b0}}; ol2 <= {NCH{1'b0}}; ol3 <= {NCH{1'b0}};
			sg1 <= {NCH{1'b0}}; sg2 <= {NCH{1'b0}}; sg3 <= {NCH{1'b0}};
			oc_f <= {NCH{1'b0}}; ot_f <= {NCH{1'b0}};
			ol_f <= {NCH{1'b0}}; sg_f <= {NCH{1'b0}};
		end else begin
			inj_s <= {inj_s[0], injector_stage_enable};
			inj_s3 <= inj_s[1];
			if (inj_s[1] == inj_s3) begin
				inj_q <= inj_s3;
			end
			tmo_s <= {tmo_s[0], link_timeout};
			tmo_s3 <= tmo_s[1];
			if (tmo_s[1] == tmo_s3) begin
				tmo_q <= tmo_s3;
			end
			oc1 <= oc_raw; oc2 <= oc1; oc3 <= oc2;
			ot1 <= ot_raw; ot2 <= ot1; ot3 <= ot2;
			ol1 <= ol_raw; ol2 <= ol1; ol3 <= ol2;
			sg1 <= scg_raw; sg2 <= sg1; sg3 <= sg2;
			// a bit changes only when stages two and three agree
			oc_f <= (oc2 & oc3) | (oc_f & (oc2 | oc3));
			ot_f <= (ot2 & ot3) | (ot_f & (ot2 | ot3));
			ol_f <= (ol2 & ol3) | (ol_f & (ol2 | ol3));
			sg_f <= (sg2 & sg3) | (sg_f & (sg2 | sg3));
		end
	end

	genvar g;
	generate
		for (g = 0; g < NCH; g = g + 1) begin : g_ch
			reg [CW-1:0] occ_q, dgc_q;
			// first four channels are the injector stages
			assign allow[g] = on_q[g] & ~tmo_q & (g >= 4 || inj_q)
				& ~otl_q[g] & ~octrip_q[g];
			always @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					occ_q <= {CW{1'b0}};
					dgc_q <= {CW{1'b0}};
					ocdet_q[g] <= 1'b0;
					octrip_q[g] <= 1'b0;
					otl_q[g] <= 1'b0;
					offdiag_q[g] <= 1'b0;
					ol_lat_q[g] <= 1'b0;
					scg_lat_q[g] <= 1'b0;
					ev_oc[g] <= 1'b0;
				end else begin
					ev_oc[g] <= 1'b0;
					// filter runs only while on, current is limited meanwhile
					if (oc_f[g] && gate_on[g]) begin
						if (occ_q < TOC_C) begin
							occ_q <= occ_q + 1'b1;
						end else if (!ocdet_q[g]) begin
							ocdet_q[g] <= 1'b1;
							ev_oc[g] <= 1'b1;
							if (ocmode_q[g]) begin
								octrip_q[g] <= 1'b1;
							end
						end
					end else begin
						occ_q <= {CW{1'b0}};
						if (!oc_f[g]) begin
							ocdet_q[g] <= 1'b0;
						end
					end
					// tripped channel stays off until software turns it off
					if (!on_q[g]) begin
						octrip_q[g] <= 1'b0;
					end
					// ot_raw is the comparator with hysteresis already in it
					otl_q[g] <= ot_f[g];
					offdiag_q[g] <= ~on_q[g];
					if (on_q[g]) begin
						dgc_q <= {CW{1'b0}};
					end else if (dgc_q < TDG_C) begin
						dgc_q <= dgc_q + 1'b1;
					end else begin
						ol_lat_q[g] <= ol_f[g];
						scg_lat_q[g] <= sg_f[g];
					end
				end
			end
			always @* begin
				// pull-down disable suppresses open load only, or open load and short on 18-20
				if (otl_q[g] || ocdet_q[g]) begin
					cur_code[2*g+1:2*g] = `LSSW_CODE_BATT;
				end else if (pddis_q[g] && g >= `LSSW_FIRST_UPPER) begin
					cur_code[2*g+1:2*g] = `LSSW_CODE_NONE;
				end else if (ol_lat_q[g] && !pddis_q[g]) begin
					cur_code[2*g+1:2*g] = `LSSW_CODE_OPEN;
				end else if (scg_lat_q[g]) begin
					cur_code[2*g+1:2*g] = `LSSW_CODE_SCG;
				end else begin
					cur_code[2*g+1:2*g] = `LSSW_CODE_NONE;
				end
			end
		end
	endgenerate

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			on_q <= {NCH{1'b0}};
			ocmode_q <= {NCH{1'b0}};
			pddis_q <= {NCH{1'b0}};
			en_q <= {NCH{1'b0}};
			sts_q <= {NCH{1'b0}};
			fault_q <= {2*NCH{1'b0}};
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
			gate_on <= {NCH{1'b0}};
			diag_enable <= {NCH{1'b0}};
			pull_current_on <= {NCH{1'b0}};
			irq <= 1'b0;
		end else begin
			gate_on <= allow;
			// gate the detector with allow so it never overlaps a conducting cycle
			diag_enable <= offdiag_q & ~allow;
			pull_current_on <= offdiag_q & ~allow & ~pddis_q;
			// fault field ORs in each new code bitwise until read; read refreshes
			if (rd && pready && paddr == `LSSW_ADDR_FAULT) begin
				fault_q <= cur_code;
			end else begin
				fault_q <= fault_q | cur_code;
			end
			// set wins over clear
			sts_q <= (sts_q & ~((wr && pready && paddr == `LSSW_ADDR_IRQCLR) ?
				pwdata[NCH-1:0] : {NCH{1'b0}})) | ev_oc | (otl_q & ~ot_f);
			irq <= |(sts_q & en_q);
			pready <= psel & ~pready;
			pslverr <= 1'b0;
			if (psel && !pready) begin
				prdata <= 32'h00000000;
				case (paddr)
				`LSSW_ADDR_ON:      prdata[NCH-1:0] <= on_q;
				`LSSW_ADDR_OCMODE:  prdata[NCH-1:0] <= ocmode_q;
				`LSSW_ADDR_PDDIS:   prdata[NCH-1:0] <= pddis_q;
				`LSSW_ADDR_FAULT:   prdata[2*NCH-1:0] <= fault_q;
				`LSSW_ADDR_STATUS:  prdata[NCH-1:0] <= sts_q;
				`LSSW_ADDR_IRQEN:   prdata[NCH-1:0] <= en_q;
				`LSSW_ADDR_IRQCLR:  prdata <= 32'h00000000;
				`LSSW_ADDR_OUTSTAT: prdata[NCH-1:0] <= gate_on;
				default:            pslverr <= 1'b1;
				endcase
				// raised in setup so it stands at the pready edge
				if (paddr > `LSSW_ADDR_OUTSTAT || paddr[1:0] != 2'b00) begin
					pslverr <= 1'b1;
				end
			end
			if (wr && pready) begin
				case (paddr)
				`LSSW_ADDR_ON:     on_q <= pwdata[NCH-1:0];
				`LSSW_ADDR_OCMODE: ocmode_q <= pwdata[NCH-1:0];
				`LSSW_ADDR_PDDIS:  pddis_q <= pwdata[NCH-1:0];
				`LSSW_ADDR_IRQEN:  en_q <= pwdata[NCH-1:0];
				default:           en_q <= en_q;
				endcase
			end
		end
	end
endmodule

// >>> lssw_checker.sv
// port assertions for the low-side switch block
`timescale 1ns/1ps
module lssw_checker #(
	parameter NCH = 14
) (
	input logic           pclk,
	input logic           presetn,
	input logic           psel,
	input logic           penable,
	input logic           pready,
	input logic           pslverr,
	input logic           injector_stage_enable,
	input logic           link_timeout,
	input logic [NCH-1:0] ot_raw,
	input logic [NCH-1:0] gate_on,
	input logic [NCH-1:0] diag_enable,
	input logic [NCH-1:0] pull_current_on
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// pin is synchronised, so allow eight cycles
	a_inj_gate_off: assert property (!injector_stage_enable [*8] |-> gate_on[3:0] == 4'h0)
		else $error("injector channels on without enable");
	a_gate_inj_rise: assert property ($rose(gate_on[0]) |-> $past(injector_stage_enable, 3))
		else $error("channel one rose without enable pin");
	a_timeout_off: assert property (link_timeout [*8] |-> gate_on == '0)
		else $error("stage on during link timeout");
	a_ot_hold_off: assert property ($stable(ot_raw) [*8] |-> (ot_raw & gate_on) == '0)
		else $error("hot channel still on");
	a_diag_when_off: assert property ((diag_enable & gate_on) == '0)
		else $error("detector enabled on a conducting channel");
	a_pull_needs_diag: assert property ((pull_current_on & ~diag_enable) == '0)
		else $error("pull current outside off diagnosis");
	a_ready_phase: assert property (pready |-> psel && penable)
		else $error("ready outside access phase");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	a_ready_wait: assert property (psel && !penable |=> ##[0:1] pready)
		else $error("no ready after setup");
	cover property ($fell(gate_on[4]));
	cover property (pready && pslverr);
	cover property ($rose(|pull_current_on));
endmodule
bind lssw_top lssw_checker #(.NCH(NCH)) u_chk (.pclk, .presetn, .psel, .penable, .pready,
	.pslverr, .injector_stage_enable, .link_timeout, .ot_raw, .gate_on, .diag_enable,
	.pull_current_on);

// >>> lssw_loads.sv
// behavioural loads giving raw detector levels
`timescale 1ns/1ps
module lssw_loads (
	input  logic [13:0] gate_on,
	input  logic [13:0] diag_enable,
	input  logic [13:0] sbat,
	input  logic [13:0] opn,
	input  logic [13:0] sgnd,
	output logic [13:0] oc_raw,
	output logic [13:0] ol_raw,
	output logic [13:0] scg_raw
);
	// raw levels only; suppression is the block's job
	assign oc_raw  = gate_on & sbat;
	assign ol_raw  = diag_enable & opn;
	assign scg_raw = diag_enable & sgnd;
endmodule

// >>> tb_top.sv
// self-checking bench for the low-side switch block
`timescale 1ns/1ps
module tb_top;
	localparam TOC = 20;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, inj = 0, tmo = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	logic        pready, pslverr, irq, err;
	logic [13:0] ot = 0, sbat = 0, opn = 0, sgnd = 0, oc, ol, scg, gate, den, pull;
	int          fail_count = 0, samples_checked = 0;
	always #2.5 pclk = ~pclk;
	lssw_top #(.TOC_CYC(TOC), .TDIAG_CYC(20)) DUT (.pclk, .presetn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .injector_stage_enable(inj),
		.link_timeout(tmo), .oc_raw(oc), .ot_raw(ot), .ol_raw(ol), .scg_raw(scg),
		.gate_on(gate), .diag_enable(den), .pull_current_on(pull), .irq);
	lssw_loads LD (.gate_on(gate), .diag_enable(den), .sbat, .opn, .sgnd, .oc_raw(oc),
		.ol_raw(ol), .scg_raw(scg));
	task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			$display("Error %s expected %h seen %h", nm, exp, got);
			fail_count++;
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) fail_count++;
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task t_inj;
		apb(1, 12'h000, 32'hf);
		cyc(10);
		chk("inj_low", gate[3:0], 0);
		inj <= 1;
		cyc(10);
		chk("inj_high", gate[3:0], 4'hf);
		tmo <= 1;
		cyc(10);
		chk("timeout", gate, 0);
		tmo <= 0;
		apb(1, 12'h000, 0);
		apb(0, 12'h020, 0);
		chk("unmapped", {err, rd[30:0]}, 32'h80000000);
		$display("done inject");
	endtask
	task t_oc;
		apb(1, 12'h004, 32'h10);
		apb(1, 12'h014, 32'h10);
		apb(1, 12'h000, 32'h30);
		sbat <= 14'h30;
		cyc(TOC - 6);
		sbat <= 0;
		cyc(10);
		chk("oc_short", gate[5:4], 2'b11);
		sbat <= 14'h30;
		cyc(TOC + 20);
		chk("oc_trip", gate[5:4], 2'b10);
		chk("irq_set", irq, 1);
		apb(0, 12'h010, 0);
		chk("status", rd[13:0], 14'h0030);
		sbat <= 0;
		apb(0, 12'h00c, 0);
		chk("oc_code", rd[11:8], 4'h5);
		apb(1, 12'h018, 32'h30);
		cyc(3);
		chk("irq_clr", irq, 0);
		apb(1, 12'h000, 32'h20);
		ot <= 14'h20;
		cyc(10);
		chk("ot_off", gate[5], 0);
		ot <= 0;
		cyc(10);
		chk("ot_release", gate[5], 1);
		apb(0, 12'h00c, 0);
		chk("ot_code", rd[11:10], 2'b01);
		apb(1, 12'h000, 0);
		$display("done protect");
	endtask
	task t_diag;
		apb(1, 12'h008, 32'h1500);
		opn <= 14'h340;
		sgnd <= 14'h1680;
		cyc(60);
		chk("pull", pull, 14'h2aff);
		chk("den", den, 14'h3fff);
		apb(0, 12'h00c, 0);
		apb(0, 12'h00c, 0);
		chk("diag_code", rd, 32'h38e000);
		opn <= 0;
		sgnd <= 0;
		cyc(60);
		apb(0, 12'h00c, 0);
		apb(0, 12'h00c, 0);
		chk("diag_clear", rd, 0);
		$display("done diagnose");
	endtask
	task results;
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	initial begin
		cyc(3);
		presetn <= 1;
		t_inj;
		t_oc;
		t_diag;
		results;
	end
	// whole run needs well under a few thousand cycles
	initial begin
		#100000;
		fail_count++;
		results;
	end
endmodule
